// ===== design/ghc_defines.svh
// Shared constants of the gyro host control front end
`ifndef GHC_DEFINES_SVH
`define GHC_DEFINES_SVH
// Clock rate and turn-on time after standby
`define GHC_CLK_HZ 10000000
`define GHC_STBY_TURNON_US 5000
`define GHC_STBY_TURNON_CYC ((`GHC_STBY_TURNON_US * (`GHC_CLK_HZ / 1000000)))
// Upper six bits of the serial slave address
`define GHC_I2C_BASE 6'h2C
`define GHC_I2C_BITS 4'h8
// Eco mode output data rates in Hz
`define GHC_ECO_ODR0 16'h0019
`define GHC_ECO_ODR1 16'h0032
`define GHC_ECO_ODR2 16'h0064
`define GHC_ECO_ODR3 16'h00C8
// Raw rate shift for the narrowest range of each table
`define GHC_SHIFT_UI 5'h05
`define GHC_SHIFT_OIS 5'h02
// Saturation limits of a 16-bit sample
`define GHC_SAT_POS 16'h7FFF
`define GHC_SAT_NEG 16'h8000
// Interrupt source positions
`define GHC_SRC_DRDY 0
`define GHC_SRC_FRDY 1
`define GHC_SRC_FTHR 2
`define GHC_SRC_FOVR 3
`define GHC_SRC_RST 4
`define GHC_SRC_SYNC 5
`endif

// ===== design/ghc_pkg.sv
// Types of the gyro host control front end
package ghc_pkg;
   typedef enum logic [1:0] {
      ghc_pm_normal = 2'b00,
      ghc_pm_eco = 2'b01,
      ghc_pm_stby = 2'b10,
      ghc_pm_pdown = 2'b11
   } ghc_pmode_e;
   typedef enum logic [1:0] {
      ghc_im_latched = 2'b00,
      ghc_im_unlatched = 2'b01,
      ghc_im_timed = 2'b10
   } ghc_imode_e;
   typedef enum logic [1:0] {
      ghc_i2c_idle = 2'b00,
      ghc_i2c_addr = 2'b01,
      ghc_i2c_ack = 2'b10,
      ghc_i2c_busy = 2'b11
   } ghc_i2c_e;
endpackage : ghc_pkg

// ===== design/ghc_int_gen.sv
// One interrupt generator with latched, unlatched and timed output
`timescale 1ns/100ps
`default_nettype none
module ghc_int_gen #(
   parameter int W = 6,
   parameter int LW = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sources
   input wire logic [W-1:0] ev,
   input wire logic [W-1:0] cond,
   // Configuration
   input wire logic [W-1:0] en,
   input wire ghc_pkg::ghc_imode_e mode,
   input wire logic act_high,
   input wire logic clr_on_rd,
   input wire logic [LW-1:0] len,
   // Status access
   input wire logic rd,
   input wire logic wr,
   input wire logic [W-1:0] wr_mask,
   output logic [W-1:0] lat,
   output logic [W-1:0] now,
   // Pin
   output logic int_pin
);
   logic [LW-1:0] tmr;
   logic lvl;
   wire [W-1:0] hit = ev & en;
   wire clr_all = rd & clr_on_rd;
   wire clr_wr = wr & ~clr_on_rd;
   wire [W-1:0] clr = clr_all ? {W{1'b1}} : (clr_wr ? wr_mask : {W{1'b0}});
   wire [W-1:0] next_lat = (lat & ~clr) | hit; // set wins over clear
   wire timed = (mode == ghc_pkg::ghc_im_timed);

   // Output level per behaviour
   always_comb begin
      unique case (mode)
         ghc_pkg::ghc_im_latched: lvl = |lat;
         ghc_pkg::ghc_im_unlatched: lvl = |(cond & en);
         ghc_pkg::ghc_im_timed: lvl = (tmr != {LW{1'b0}});
         default: lvl = 1'b0;
      endcase
   end

   // Status, pulse timer and pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lat <= {W{1'b0}};
         now <= {W{1'b0}};
         tmr <= {LW{1'b0}};
         int_pin <= 1'b0;
      end else begin
         lat <= next_lat;
         now <= cond & en;
         if (timed && (|hit)) begin
            tmr <= len; // each event restarts the pulse
         end else if (tmr != {LW{1'b0}}) begin
            tmr <= tmr - 1'b1;
         end
         int_pin <= act_high ? lvl : ~lvl;
      end
   end

   ////////////////////////////////////////////////////////////////
   property p_lat_set;
      @(posedge clk) disable iff (rst) (|hit) |=> ((lat & $past(hit)) == $past(hit));
   endproperty
   a_lat_set: assert property (p_lat_set) else $error("enabled event not latched");

   property p_timed_len;
      @(posedge clk) disable iff (rst)
         (timed && (|hit) && len == 8'h03) |=> ##1 (int_pin == act_high) [*3] ##1 (int_pin != act_high);
   endproperty
   a_timed_len: assert property (p_timed_len) else $error("timed pulse length wrong");

   property p_clr_rd;
      @(posedge clk) disable iff (rst) (clr_all && !(|hit)) |=> (lat == {W{1'b0}});
   endproperty
   a_clr_rd: assert property (p_clr_rd) else $error("clear on read failed");

   property p_unlat;
      @(posedge clk) disable iff (rst)
         (mode == ghc_pkg::ghc_im_unlatched && $stable(mode) && $stable(act_high))
         |=> (int_pin == ($past(act_high) ~^ (|($past(cond) & $past(en)))));
   endproperty
   a_unlat: assert property (p_unlat) else $error("unlatched pin does not follow");
endmodule : ghc_int_gen
`default_nettype wire

// ===== design/ghc_front_end.sv
// Gyro host control front end: pins, power modes, samples, interrupts
// What this block does
// - Two independent interrupt generators, each with its own output pin.
// - Sources: data ready, buffer ready, threshold, overrun, restart, sync pin.
// - Every source has its own enable and its own clear.
// - Each pin behaves latched, unlatched or timed.
// - Latched status clears on read or on written mask, as selected.
// - Status readable both latched and as current condition.
// - Software picks pin level, duration, clearing method and triggers.
// - Temperature split in two bytes: whole degrees, then 1/256 degree.
// - Four power modes, set by software or woken by sync pin.
// - Eco mode only with 25, 50, 100 or 200 Hz data rate.
// - Standby makes no data; leaving it waits about 5 ms.
// - Power-down keeps registers reachable but makes no samples.
// - Range: 250..2000 dps interface table, 31.25..250 dps stabilization table.
// - Rates beyond range saturate at the limit.
// - Each axis sample is a 16-bit result.
// - Chip select high means two-wire bus, low enables SPI.
// - Two-wire slave address is b101100 plus address-select pin.
// - Device is only a slave on the two-wire bus.
// - SPI runs as 3-wire or 4-wire, chosen by software.
// - Address b1011000 with select low, b1011001 with select high.
`include "ghc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module ghc_front_end #(
   parameter int STBY_CYC = `GHC_STBY_TURNON_CYC,
   parameter int PDOWN_CYC = `GHC_STBY_TURNON_CYC,
   parameter int RAW_W = 24,
   parameter int LEN_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire logic cs_pin,
   input wire logic scl_pin,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_pin,
   output logic sdo_out,
   output logic sdo_oe,
   // Sync pin and interrupt pins
   input wire logic sync_wake_pin,
   output logic int1_pin,
   output logic int2_pin,
   // Interface configuration and serial data from register layer
   input wire logic spi_three_wire,
   input wire logic spi_tx_bit,
   input wire logic spi_tx_act,
   output logic i2c_mode,
   output logic i2c_addr_hit,
   output logic i2c_rw,
   // Power configuration and state
   input wire ghc_pkg::ghc_pmode_e req_mode,
   input wire logic sync_wake_en,
   input wire logic [15:0] odr_hz,
   output ghc_pkg::ghc_pmode_e pmode,
   output logic data_on,
   // Range and samples
   input wire logic stabilization_range,
   input wire logic [1:0] range_sel,
   input wire logic sample_strobe,
   input wire logic [RAW_W-1:0] rate_raw_x,
   input wire logic [RAW_W-1:0] rate_raw_y,
   input wire logic [RAW_W-1:0] rate_raw_z,
   output logic [15:0] rate_x,
   output logic [15:0] rate_y,
   output logic [15:0] rate_z,
   // Temperature
   input wire logic [15:0] temp_raw,
   output logic [7:0] temp_deg,
   output logic [7:0] temp_frac,
   // Buffer condition levels
   input wire logic fifo_ready,
   input wire logic fifo_thresh,
   input wire logic fifo_overrun,
   // Interrupt generator 1
   input wire logic [5:0] int1_en,
   input wire ghc_pkg::ghc_imode_e int1_mode,
   input wire logic int1_act_high,
   input wire logic int1_clr_on_rd,
   input wire logic [LEN_W-1:0] int1_len,
   input wire logic int1_rd,
   input wire logic int1_wr,
   input wire logic [5:0] int1_mask,
   output logic [5:0] int1_lat,
   output logic [5:0] int1_now,
   // Interrupt generator 2
   input wire logic [5:0] int2_en,
   input wire ghc_pkg::ghc_imode_e int2_mode,
   input wire logic int2_act_high,
   input wire logic int2_clr_on_rd,
   input wire logic [LEN_W-1:0] int2_len,
   input wire logic int2_rd,
   input wire logic int2_wr,
   input wire logic [5:0] int2_mask,
   output logic [5:0] int2_lat,
   output logic [5:0] int2_now
);
   ////////////////////////////////////////////////////////////////
   // Pin synchronisers: stage one feeds stage two only
   logic [4:0] sy1;
   logic [4:0] sy2;
   logic [4:0] sy3;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sy1 <= 5'h1F;
         sy2 <= 5'h1F;
         sy3 <= 5'h1F;
      end else begin
         sy1 <= {sync_wake_pin, addr_select_pin, sda_in, scl_pin, cs_pin};
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   wire cs_s = sy2[0];
   wire scl_s = sy2[1];
   wire sda_s = sy2[2];
   wire asel_s = sy2[3];
   wire sync_s = sy2[4];
   wire scl_rise = scl_s & ~sy3[1];
   wire scl_fall = ~scl_s & sy3[1];
   wire sda_fall = ~sda_s & sy3[2];
   wire sda_rise = sda_s & ~sy3[2];
   wire sync_rise = sync_s & ~sy3[4];
   assign i2c_mode = cs_s;

   ////////////////////////////////////////////////////////////////
   // Two-wire slave: address match and acknowledge only
   ghc_pkg::ghc_i2c_e ist;
   ghc_pkg::ghc_i2c_e next_ist;
   logic [7:0] ish;
   logic [3:0] icnt;
   wire i_start = cs_s & scl_s & sda_fall;
   wire i_stop = cs_s & scl_s & sda_rise;
   wire [6:0] my_addr = {`GHC_I2C_BASE, asel_s};
   wire addr_ok = (ish[7:1] == my_addr);
   wire byte_done = (icnt == `GHC_I2C_BITS);

   // Slave only: never drives the clock, only acks its address
   always_comb begin
      next_ist = ist;
      unique case (ist)
         ghc_pkg::ghc_i2c_idle: if (i_start) next_ist = ghc_pkg::ghc_i2c_addr;
         ghc_pkg::ghc_i2c_addr: begin
            if (i_stop || !cs_s) begin
               next_ist = ghc_pkg::ghc_i2c_idle;
            end else if (byte_done && scl_fall) begin
               next_ist = addr_ok ? ghc_pkg::ghc_i2c_ack : ghc_pkg::ghc_i2c_busy;
            end
         end
         ghc_pkg::ghc_i2c_ack: if (scl_fall) next_ist = ghc_pkg::ghc_i2c_busy;
         ghc_pkg::ghc_i2c_busy: begin
            if (i_start) begin
               next_ist = ghc_pkg::ghc_i2c_addr;
            end else if (i_stop || !cs_s) begin
               next_ist = ghc_pkg::ghc_i2c_idle;
            end
         end
      endcase
   end

   // Shift register and bit count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ist <= ghc_pkg::ghc_i2c_idle;
         ish <= 8'h00;
         icnt <= 4'h0;
      end else begin
         ist <= next_ist;
         if (i_start) begin
            icnt <= 4'h0;
         end else if (ist == ghc_pkg::ghc_i2c_addr && scl_rise) begin
            ish <= {ish[6:0], sda_s};
            icnt <= icnt + 4'h1;
         end
      end
   end

   // Match pulse and direction bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         i2c_addr_hit <= 1'b0;
         i2c_rw <= 1'b0;
      end else begin
         i2c_addr_hit <= (ist == ghc_pkg::ghc_i2c_addr) && (next_ist == ghc_pkg::ghc_i2c_ack);
         if ((ist == ghc_pkg::ghc_i2c_addr) && (next_ist == ghc_pkg::ghc_i2c_ack)) begin
            i2c_rw <= ish[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pin drivers, registered; SPI only with chip select low
   wire spi_on = ~cs_s & spi_tx_act;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         sdo_out <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sda_out <= cs_s ? 1'b0 : spi_tx_bit; // Ack pulls low
         sda_oe <= cs_s ? (next_ist == ghc_pkg::ghc_i2c_ack) : (spi_on & spi_three_wire);
         sdo_out <= spi_tx_bit;
         sdo_oe <= spi_on & ~spi_three_wire; // select pin is input in two-wire use
      end
   end

   ////////////////////////////////////////////////////////////////
   // Power modes and turn-on delay
   ghc_pkg::ghc_pmode_e req_q;
   logic [31:0] ton;
   logic restart_ev;
   wire eco_ok = (odr_hz == `GHC_ECO_ODR0) || (odr_hz == `GHC_ECO_ODR1) ||
                 (odr_hz == `GHC_ECO_ODR2) || (odr_hz == `GHC_ECO_ODR3);
   wire pm_idle = (pmode == ghc_pkg::ghc_pm_stby) || (pmode == ghc_pkg::ghc_pm_pdown);
   wire sw_chg = (req_mode != req_q) || (pmode == ghc_pkg::ghc_pm_eco && !eco_ok);
   wire sync_wake = sync_wake_en & sync_rise & pm_idle;
   // Refused eco falls back to normal rather than holding the old mode
   wire ghc_pkg::ghc_pmode_e sw_mode = (req_mode == ghc_pkg::ghc_pm_eco && !eco_ok) ?
                                       ghc_pkg::ghc_pm_normal : req_mode;
   wire ghc_pkg::ghc_pmode_e next_pm = sync_wake ? ghc_pkg::ghc_pm_normal :
                                      (sw_chg ? sw_mode : pmode);
   wire leaving = pm_idle && (next_pm == ghc_pkg::ghc_pm_normal || next_pm == ghc_pkg::ghc_pm_eco);
   wire [31:0] ton_load = (pmode == ghc_pkg::ghc_pm_stby) ? 32'(STBY_CYC) : 32'(PDOWN_CYC);
   assign data_on = !pm_idle && (ton == 32'h0000_0000);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pmode <= ghc_pkg::ghc_pm_normal;
         req_q <= ghc_pkg::ghc_pm_normal;
         ton <= 32'h0000_0000;
         restart_ev <= 1'b0;
      end else begin
         pmode <= next_pm;
         req_q <= req_mode;
         restart_ev <= (ton == 32'h0000_0001); // Start-up sequence done
         if (leaving) begin
            ton <= ton_load;
         end else if (!(next_pm == ghc_pkg::ghc_pm_normal || next_pm == ghc_pkg::ghc_pm_eco)) begin
            ton <= 32'h0000_0000;
         end else if (ton != 32'h0000_0000) begin
            ton <= ton - 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Range scaling and saturation, one lane per axis
   logic [RAW_W-1:0] raw [3];
   logic [15:0] rout [3];
   logic drdy_ev;
   assign raw[0] = rate_raw_x;
   assign raw[1] = rate_raw_y;
   assign raw[2] = rate_raw_z;
   assign rate_x = rout[0];
   assign rate_y = rout[1];
   assign rate_z = rout[2];
   wire [4:0] shamt = (stabilization_range ? `GHC_SHIFT_OIS : `GHC_SHIFT_UI) + {3'h0, range_sel};
   wire take = sample_strobe & data_on;

   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++) begin : g_axis
         wire signed [RAW_W-1:0] sh = $signed(raw[ax]) >>> shamt;
         wire hi = (sh > $signed(RAW_W'(32767)));
         wire lo = (sh < $signed(-RAW_W'(32768)));
         wire [15:0] sat = hi ? `GHC_SAT_POS : (lo ? `GHC_SAT_NEG : sh[15:0]);
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               rout[ax] <= 16'h0000;
            end else if (take) begin
               rout[ax] <= sat;
            end
         end
      end
   endgenerate

   // Temperature bytes and sample event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_deg <= 8'h00;
         temp_frac <= 8'h00;
         drdy_ev <= 1'b0;
      end else begin
         temp_deg <= temp_raw[15:8];
         temp_frac <= temp_raw[7:0];
         drdy_ev <= take;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Interrupt sources: buffer events on rising edges of their levels
   logic [2:0] fifo_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifo_q <= 3'h0;
      end else begin
         fifo_q <= {fifo_overrun, fifo_thresh, fifo_ready};
      end
   end
   wire [2:0] fifo_ev = {fifo_overrun, fifo_thresh, fifo_ready} & ~fifo_q;
   wire [5:0] src_ev = {sync_rise, restart_ev, fifo_ev, drdy_ev};
   wire [5:0] src_lvl = {sync_s, restart_ev, fifo_overrun, fifo_thresh, fifo_ready, drdy_ev};

   // Two generators share sources but nothing else
   ghc_int_gen #(.W(6), .LW(LEN_W)) u_int1 (
      .clk(clk), .rst(rst), .ev(src_ev), .cond(src_lvl), .en(int1_en), .mode(int1_mode),
      .act_high(int1_act_high), .clr_on_rd(int1_clr_on_rd), .len(int1_len), .rd(int1_rd),
      .wr(int1_wr), .wr_mask(int1_mask), .lat(int1_lat), .now(int1_now), .int_pin(int1_pin)
   );
   ghc_int_gen #(.W(6), .LW(LEN_W)) u_int2 (
      .clk(clk), .rst(rst), .ev(src_ev), .cond(src_lvl), .en(int2_en), .mode(int2_mode),
      .act_high(int2_act_high), .clr_on_rd(int2_clr_on_rd), .len(int2_len), .rd(int2_rd),
      .wr(int2_wr), .wr_mask(int2_mask), .lat(int2_lat), .now(int2_now), .int_pin(int2_pin)
   );

   ////////////////////////////////////////////////////////////////
   property p_ack_low;
      @(posedge clk) disable iff (rst) (ist == ghc_pkg::ghc_i2c_ack) |-> (sda_oe && !sda_out);
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack not driven low");

   property p_addr;
      @(posedge clk) disable iff (rst) i2c_addr_hit |-> ($past(ish[7:1]) == {`GHC_I2C_BASE, asel_s});
   endproperty
   a_addr: assert property (p_addr) else $error("wrong address acknowledged");

   property p_sat;
      @(posedge clk) disable iff (rst)
         (take && !stabilization_range && range_sel == 2'h0 && $signed(rate_raw_x) > $signed(24'h1FFFFF))
         |=> (rate_x == `GHC_SAT_POS);
   endproperty
   a_sat: assert property (p_sat) else $error("rate not saturated");

   property p_temp;
      @(posedge clk) disable iff (rst) 1'b1 |=> ({temp_deg, temp_frac} == $past(temp_raw));
   endproperty
   a_temp: assert property (p_temp) else $error("temperature bytes wrong");

   property p_no_data_idle;
      @(posedge clk) disable iff (rst) pm_idle |=> !drdy_ev;
   endproperty
   a_no_data_idle: assert property (p_no_data_idle) else $error("sample in standby or power-down");

   property p_wake_wait;
      @(posedge clk) disable iff (rst) (leaving && pmode == ghc_pkg::ghc_pm_stby) |=> !data_on [*8];
   endproperty
   a_wake_wait: assert property (p_wake_wait) else $error("data before turn-on time");

   property p_eco_odr;
      @(posedge clk) disable iff (rst) (pmode == ghc_pkg::ghc_pm_eco) |-> $past(eco_ok) || eco_ok;
   endproperty
   a_eco_odr: assert property (p_eco_odr) else $error("eco with bad data rate");

   property p_wire_sel;
      @(posedge clk) disable iff (rst) (sdo_oe |-> (!$past(spi_three_wire) && !$past(cs_s)));
   endproperty
   a_wire_sel: assert property (p_wire_sel) else $error("data out pin driven wrongly");

   c_ack: cover property (@(posedge clk) disable iff (rst) i2c_addr_hit);
   c_wake: cover property (@(posedge clk) disable iff (rst) sync_wake ##[1:100] restart_ev);
   c_int1: cover property (@(posedge clk) disable iff (rst) $rose(int1_pin));
endmodule : ghc_front_end
`default_nettype wire

// ===== tb/ghc_host_model.sv
// Two-wire bus master model on the far side of the front end
`timescale 1ns/100ps
`default_nettype none
module ghc_host_model (
   // Bus lines
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   // Bus idles released, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   ////////////////////////////////////////
   // Address frame at 800 ns per bit; host is always master
   task automatic send(input logic [7:0] b, output logic ack);
      sda_drv = 1'b0;
      #400 scl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #200 sda_drv = b[i]; // MSB first, changed with clock low
         #200 scl = 1'b1;
         #400 scl = 1'b0;
      end
      #200 sda_drv = 1'b1; // Released so the slave can answer
      #200 scl = 1'b1;
      #200 ack = sda;
      #200 scl = 1'b0;
      #200 sda_drv = 1'b0;
      #200 scl = 1'b1;
      #200 sda_drv = 1'b1; // Stop
      #400;
   endtask : send
endmodule : ghc_host_model
`default_nettype wire

// ===== tb/ghc_front_end_tb.sv
// Testbench of the gyro host control front end
`timescale 1ns/100ps
`default_nettype none
module ghc_front_end_tb;
   // Bench drives
   logic clk, rst, cs, sel, syn, tw, txb, txa, swen, stb, stab, fr, ft, fo, ack;
   logic a_h, a_c, a_r, a_w, b_h, b_c, b_r, b_w;
   logic [1:0] rsel;
   logic [15:0] odr, traw;
   logic [23:0] rx, ry, rz;
   logic [5:0] a_en, a_m, b_en, b_m;
   logic [7:0] a_len, b_len;
   ghc_pkg::ghc_pmode_e rmode;
   ghc_pkg::ghc_imode_e a_md, b_md;
   // Design outputs
   logic so, soe, dq, doe, i1, i2, im, hit, rw, don, scl, sdrv;
   ghc_pkg::ghc_pmode_e pm;
   logic [15:0] qx, qy, qz;
   logic [7:0] tdg, tfr;
   logic [5:0] a_lat, a_now, b_lat, b_now;
   int errors, n_checks, hits, k;
   // Pulled-up data wire, any low driver wins
   wire sda = sdrv & ~(soe & ~so);
   // Short turn-on counts keep the run brief
   ghc_front_end #(.STBY_CYC(20), .PDOWN_CYC(20)) dut (
      .clk(clk), .rst(rst), .cs_pin(cs), .scl_pin(scl), .sda_in(sda), .sda_out(so), .sda_oe(soe),
      .addr_select_pin(sel), .sdo_out(dq), .sdo_oe(doe), .sync_wake_pin(syn), .int1_pin(i1), .int2_pin(i2),
      .spi_three_wire(tw), .spi_tx_bit(txb), .spi_tx_act(txa), .i2c_mode(im), .i2c_addr_hit(hit), .i2c_rw(rw),
      .req_mode(rmode), .sync_wake_en(swen), .odr_hz(odr), .pmode(pm), .data_on(don),
      .stabilization_range(stab), .range_sel(rsel), .sample_strobe(stb), .rate_raw_x(rx), .rate_raw_y(ry),
      .rate_raw_z(rz), .rate_x(qx), .rate_y(qy), .rate_z(qz), .temp_raw(traw), .temp_deg(tdg), .temp_frac(tfr),
      .fifo_ready(fr), .fifo_thresh(ft), .fifo_overrun(fo),
      .int1_en(a_en), .int1_mode(a_md), .int1_act_high(a_h), .int1_clr_on_rd(a_c), .int1_len(a_len),
      .int1_rd(a_r), .int1_wr(a_w), .int1_mask(a_m), .int1_lat(a_lat), .int1_now(a_now),
      .int2_en(b_en), .int2_mode(b_md), .int2_act_high(b_h), .int2_clr_on_rd(b_c), .int2_len(b_len),
      .int2_rd(b_r), .int2_wr(b_w), .int2_mask(b_m), .int2_lat(b_lat), .int2_now(b_now));
   ghc_host_model hm (.scl(scl), .sda_drv(sdrv), .sda(sda));
   ////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Address hits are one-cycle pulses, so count them here
   always @(posedge clk) if (hit === 1'b1) hits <= hits + 1;
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wrap_up;
      if (errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   // Bounded wait on the latched status of the first generator
   task wlat(input logic [5:0] e);
      k = 0;
      while (a_lat !== e) begin
         tick(1);
         k++;
         if (k > 100) begin
            errors++;
            wrap_up();
         end
      end
   endtask : wlat
   task pulse_rd;
      a_r = 1'b1;
      tick(1);
      a_r = 1'b0;
      tick(2);
   endtask : pulse_rd
   task pulse_stb;
      stb = 1'b1;
      tick(1);
      stb = 1'b0;
      tick(2);
   endtask : pulse_stb
   ////////////////////////////////////////
   // Own address acknowledged, the other device's ignored; chip select stays high, address select goes low then high
   task t_i2c;
      chk("i2c_mode", 1, im);
      hm.send(8'hB0, ack);
      chk("ack low sel", 0, ack);
      hm.send(8'hB2, ack);
      chk("ack foreign", 1, ack);
      sel = 1'b1;
      hm.send(8'hB3, ack);
      chk("ack high sel", 0, ack);
      chk("i2c_rw", 1, rw);
      chk("hits", 2, hits);
   endtask : t_i2c
   // Data pin follows the wire mode chosen by software
   task t_spi;
      {cs, txa, txb} = 3'h3;
      tick(4);
      chk("i2c_mode spi", 0, im);
      chk("sdo 4w", 2'h3, {doe, dq});
      chk("sda_oe 4w", 0, soe);
      tw = 1'b1;
      txb = 1'b0;
      tick(4);
      chk("sda 3w", 2'h2, {soe, so});
      chk("sdo_oe 3w", 0, doe);
      {cs, txa} = 2'h2;
      tick(4);
   endtask : t_spi
   // Latched pin, per-source enables, both clearing methods
   task t_latched;
      a_en = 6'h02;
      fr = 1'b1;
      wlat(6'h02);
      tick(2);
      chk("int1_pin", 1, i1);
      chk("int1_now", 6'h02, a_now);
      chk("int2 idle", 7'h00, {b_lat, i2});
      a_m = 6'h02;
      a_w = 1'b1;
      tick(1);
      a_w = 1'b0;
      tick(1);
      chk("wr refused", 6'h02, a_lat);
      fr = 1'b0;
      pulse_rd();
      chk("rd clear", 7'h00, {a_lat, i1});
      {a_c, a_en, fr, fo} = 9'h02B;
      wlat(6'h0A);
      a_m = 6'h08;
      a_w = 1'b1;
      tick(1);
      a_w = 1'b0;
      tick(2);
      chk("mask clear", 6'h02, a_lat);
      pulse_rd();
      chk("rd refused", 6'h02, a_lat);
      {a_c, fr, fo} = 3'h4;
      pulse_rd();
   endtask : t_latched
   // Timed active-low pulse of programmed length
   task t_timed;
      b_md = ghc_pkg::ghc_im_timed;
      {b_h, b_len, b_en} = {1'b0, 8'h03, 6'h04};
      tick(2);
      chk("int2 idle high", 1, i2);
      ft = 1'b1;
      k = 0;
      repeat (30) begin
         tick(1);
         if (i2 === 1'b0) k++;
      end
      chk("timed length", 3, k);
      chk("int2 released", 1, i2);
      // Unlatched pin follows the threshold level itself
      a_md = ghc_pkg::ghc_im_unlatched;
      a_en = 6'h04;
      tick(3);
      chk("unlatched on", 1, i1);
      ft = 1'b0;
      tick(3);
      chk("unlatched off", 0, i1);
   endtask : t_timed
   // Scaling, saturation and temperature split
   task t_rate;
      {rx, ry, rz, traw} = {24'h7FFFFF, 24'h000100, 24'h800000, 16'h19C0};
      pulse_stb();
      chk("rate_x", 16'h7FFF, qx);
      chk("rate_y", 16'h0008, qy);
      chk("rate_z", 16'h8000, qz);
      chk("temp", 16'h19C0, {tdg, tfr});
      {stab, rsel} = 3'h5;
      pulse_stb();
      chk("rate_y stab", 16'h0020, qy);
   endtask : t_rate
   // Standby, turn-on count, eco rates, power-down with sync wake
   task t_power;
      a_en = 6'h10;
      rmode = ghc_pkg::ghc_pm_stby;
      rx = 24'h000200;
      tick(3);
      chk("pmode stby", ghc_pkg::ghc_pm_stby, pm);
      pulse_stb();
      chk("no data", 16'h7FFF, qx);
      rmode = ghc_pkg::ghc_pm_normal;
      wlat(6'h10);
      chk("turn-on", 1, k >= 18 && k <= 24);
      odr = 16'h001E;
      rmode = ghc_pkg::ghc_pm_eco;
      tick(3);
      chk("eco refused", ghc_pkg::ghc_pm_normal, pm);
      // A refused eco request counts again only when requested anew
      odr = 16'h0064;
      rmode = ghc_pkg::ghc_pm_normal;
      tick(2);
      rmode = ghc_pkg::ghc_pm_eco;
      tick(3);
      chk("eco", ghc_pkg::ghc_pm_eco, pm);
      rmode = ghc_pkg::ghc_pm_pdown;
      tick(3);
      hm.send(8'hB3, ack);
      chk("pdown access", 0, {ack, don});
      {swen, syn} = 2'h3;
      tick(6);
      chk("sync wake", ghc_pkg::ghc_pm_normal, pm);
   endtask : t_power
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {rst, cs, sel, syn, tw, txb, txa, swen, stb, stab, fr, ft, fo} = 13'h1800;
      {a_h, a_c, a_r, a_w, b_h, b_c, b_r, b_w, rsel} = 10'h330;
      {odr, traw, rx, ry, rz} = '0;
      {a_en, a_m, b_en, b_m, a_len, b_len} = '0;
      rmode = ghc_pkg::ghc_pm_normal;
      a_md = ghc_pkg::ghc_im_latched;
      b_md = ghc_pkg::ghc_im_latched;
      {errors, n_checks, hits, k} = '0;
      tick(6);
      rst = 1'b0;
      tick(3);
      t_i2c();
      t_spi();
      t_latched();
      t_timed();
      t_rate();
      t_power();
      wrap_up();
   end
endmodule : ghc_front_end_tb
`default_nettype wire
